//--- design/bsrm_pkg.sv
package bsrm_pkg;
  localparam int AXI_ADDR_W = 10;
  localparam int AXI_DATA_W = 32;
  localparam int RAM_ADDR_W = 9;
  localparam int IDX_W      = 8;
  localparam int BANK_BIT   = 7;
  localparam int SYNC_W     = 3;

  localparam logic [1:0] AXI_OKAY = 2'h0;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_INDIRECT = 8'h80;
  localparam logic [7:0] IDX_OPTION   = 8'h81;
  localparam logic [7:0] IDX_PCLOW    = 8'h82;
  localparam logic [7:0] IDX_STATUS   = 8'h83;
  localparam logic [7:0] IDX_POINTER  = 8'h84;
  localparam logic [7:0] IDX_DIRA     = 8'h85;
  localparam logic [7:0] IDX_DIRB     = 8'h86;
  localparam logic [7:0] IDX_DIRC     = 8'h87;
  localparam logic [7:0] IDX_LATCH    = 8'h8a;
  localparam logic [7:0] IDX_INTCTRL  = 8'h8b;
  localparam logic [7:0] IDX_PIRQEN   = 8'h8c;
  localparam logic [7:0] IDX_CAUSE    = 8'h8e;
  localparam logic [7:0] IDX_T2PER    = 8'h92;
  localparam logic [7:0] IDX_SERADDR  = 8'h93;
  localparam logic [7:0] IDX_SERSTATE = 8'h94;

  localparam int ST_IRP = 7;
  localparam int ST_RP1 = 6;
  localparam int ST_RP0 = 5;
  localparam int ST_TO  = 4;
  localparam int ST_PD  = 3;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOR = 0;
  localparam int IRQ_FLAG_W = 3;

  localparam logic [7:0]  RST_OPTION  = 8'hff;
  localparam logic [7:0]  RST_STATUS  = 8'h18;
  localparam logic [5:0]  RST_DIRA    = 6'h3f;
  localparam logic [7:0]  RST_DIR8    = 8'hff;
  localparam logic [7:0]  RST_ZERO8   = 8'h00;
  localparam logic [4:0]  RST_LATCH   = 5'h00;
  localparam logic [7:0]  RST_T2PER   = 8'hff;
  localparam logic [1:0]  RST_CAUSE   = 2'h0;
  localparam logic [12:0] RST_PC      = 13'h0000;
endpackage : bsrm_pkg

//--- design/bsrm_axi_slave.sv
`timescale 1ns/100ps
module bsrm_axi_slave #(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   wrEn,
  output logic [7:0]             wrIndex,
  output logic [7:0]             wrData,
  output logic                   rdEn,
  output logic [7:0]             rdIndex,
  input  wire logic [7:0]        rdByte
);
  typedef struct packed {
    logic              awHave;
    logic [ADDR_W-1:0] awAddr;
    logic              wHave;
    logic [7:0]        wByte;
    logic              wLane0;
    logic              bValid;
    logic              rValid;
    logic [7:0]        rByte;
  } bsrm_axi_type;

  bsrm_axi_type q;
  bsrm_axi_type d;

  assign awready = !q.awHave && !q.bValid;
  assign wready  = !q.wHave && !q.bValid;
  assign arready = !q.rValid;
  assign bvalid  = q.bValid;
  assign rvalid  = q.rValid;
  assign bresp   = bsrm_pkg::AXI_OKAY;
  assign rresp   = bsrm_pkg::AXI_OKAY;
  assign rdata   = {24'h00_0000, q.rByte};
  // Only byte lane zero carries register data, so a write without it stores nothing.
  assign wrEn    = q.awHave && q.wHave && q.wLane0;
  assign wrIndex = q.awAddr[ADDR_W-1:2];
  assign wrData  = q.wByte;
  assign rdEn    = arvalid && !q.rValid;
  assign rdIndex = araddr[ADDR_W-1:2];

  always_comb
  begin
    d = q;
    if (awvalid && awready)
    begin
      d.awHave = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      d.wHave  = 1'b1;
      d.wByte  = wdata[7:0];
      d.wLane0 = wstrb[0];
    end
    if (q.awHave && q.wHave)
    begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
    end
    if (q.bValid && bready)
    begin
      d.bValid = 1'b0;
    end
    if (rdEn)
    begin
      d.rValid = 1'b1;
      d.rByte  = rdByte;
    end
    else if (q.rValid && rready)
    begin
      d.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule : bsrm_axi_slave

//--- design/bsrm_data_ram.sv
`timescale 1ns/100ps
module bsrm_data_ram #(
  parameter int ADDR_W = 9
) (
  input  wire logic              clk_sys,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wrData,
  output logic [7:0]             rdData
);
  // No reset: general data memory powers up unknown, as on the real part.
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  assign rdData = mem[addr];

  always_ff @(posedge clk_sys)
  begin
    if (wrEn)
    begin
      mem[addr] <= wrData;
    end
  end
endmodule : bsrm_data_ram

//--- design/bsrm_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module bsrm_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [9:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [9:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        pcAdvance,
  input  wire logic        pcJump,
  input  wire logic [10:0] jumpTarget,
  input  wire logic        externalResetPin_n,
  input  wire logic        brownoutDetect,
  input  wire logic        watchdogTimeout,
  input  wire logic [2:0]  irqFlagSet,
  input  wire logic [5:0]  serialPortStateIn,
  output logic [12:0]      programCounter,
  output logic [7:0]       timerAndPullupOptions,
  output logic [7:0]       cpuStatusFlags,
  output logic [7:0]       indirectPointer,
  output logic [5:0]       portADirection,
  output logic [7:0]       portBDirection,
  output logic [7:0]       portCDirection,
  output logic [4:0]       pcHighLatch,
  output logic [7:0]       interruptControl,
  output logic [7:0]       peripheralIrqEnable,
  output logic [1:0]       resetCauseFlags,
  output logic [7:0]       timer2Period,
  output logic [7:0]       serialPortAddress
);
  typedef struct packed {
    logic [7:0]  option;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [5:0]  dirA;
    logic [7:0]  dirB;
    logic [7:0]  dirC;
    logic [4:0]  latch;
    logic [7:0]  intCtrl;
    logic [7:0]  pirqEn;
    logic [1:0]  cause;
    logic [7:0]  t2Per;
    logic [7:0]  serAddr;
    logic [5:0]  serState;
    logic [12:0] pc;
    logic [2:0]  pinSync;
    logic [2:0]  borSync;
    logic        pinLevel;
    logic        borLevel;
  } bsrm_state_type;

  localparam bsrm_state_type RST_Q = '{
    option:   bsrm_pkg::RST_OPTION,
    status:   bsrm_pkg::RST_STATUS,
    pointer:  bsrm_pkg::RST_ZERO8,
    dirA:     bsrm_pkg::RST_DIRA,
    dirB:     bsrm_pkg::RST_DIR8,
    dirC:     bsrm_pkg::RST_DIR8,
    latch:    bsrm_pkg::RST_LATCH,
    intCtrl:  bsrm_pkg::RST_ZERO8,
    pirqEn:   bsrm_pkg::RST_ZERO8,
    cause:    bsrm_pkg::RST_CAUSE,
    t2Per:    bsrm_pkg::RST_T2PER,
    serAddr:  bsrm_pkg::RST_ZERO8,
    serState: 6'h00,
    pc:       bsrm_pkg::RST_PC,
    pinSync:  3'h7,
    borSync:  3'h0,
    pinLevel: 1'b1,
    borLevel: 1'b0
  };

  bsrm_state_type q;
  bsrm_state_type d;

  logic       wrEn;
  logic [7:0] wrIndex;
  logic [7:0] wrData;
  logic       rdEn;
  logic [7:0] rdIndex;
  logic [7:0] rdByte;
  logic [7:0] ramRdData;
  logic       ramWrEn;
  logic       pinEvent;
  logic       borEvent;
  logic       otherReset;

  function automatic logic [7:0] canonIndex(input logic [7:0] idx);
    logic [6:0] low;
    low = idx[6:0];
    if (low == 7'h00 || low == 7'h02 || low == 7'h03 || low == 7'h04 ||
        low == 7'h0a || low == 7'h0b)
    begin
      return {1'b1, low};
    end
    return idx;
  endfunction : canonIndex

  function automatic logic pointsAtPort(input logic [7:0] ptr);
    return ptr[6:0] == 7'h00;
  endfunction : pointsAtPort

  // Power-up resets also set TO and PD and clear the BOR cause bit; every reset keeps the pointer, STATUS[2:0] and intCtrl[0].
  function automatic bsrm_state_type applyReset(input bsrm_state_type s,
                                                input logic power,
                                                input logic watchdog);
    bsrm_state_type r;
    r = s;
    r.option = bsrm_pkg::RST_OPTION;
    r.pc = bsrm_pkg::RST_PC;
    r.dirA = bsrm_pkg::RST_DIRA;
    r.dirB = bsrm_pkg::RST_DIR8;
    r.dirC = bsrm_pkg::RST_DIR8;
    r.latch = bsrm_pkg::RST_LATCH;
    r.intCtrl[7:1] = 7'h00;
    r.pirqEn = bsrm_pkg::RST_ZERO8;
    r.t2Per = bsrm_pkg::RST_T2PER;
    r.serAddr = bsrm_pkg::RST_ZERO8;
    r.status[bsrm_pkg::ST_IRP:bsrm_pkg::ST_RP0] = 3'h0;
    if (power)
    begin
      r.status[bsrm_pkg::ST_TO] = 1'b1;
      r.status[bsrm_pkg::ST_PD] = 1'b1;
      r.cause[bsrm_pkg::CAUSE_BOR] = 1'b0;
    end
    else if (watchdog)
    begin
      r.status[bsrm_pkg::ST_TO] = 1'b0;
      r.status[bsrm_pkg::ST_PD] = 1'b1;
    end
    return r;
  endfunction : applyReset

  bsrm_axi_slave #(
    .ADDR_W (bsrm_pkg::AXI_ADDR_W)
  ) u_axi (
    .clk_sys (clk_sys),
    .rst     (rst),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wrEn    (wrEn),
    .wrIndex (wrIndex),
    .wrData  (wrData),
    .rdEn    (rdEn),
    .rdIndex (rdIndex),
    .rdByte  (rdByte)
  );

  assign ramWrEn = wrEn && canonIndex(wrIndex) == bsrm_pkg::IDX_INDIRECT &&
                   !pointsAtPort(q.pointer);

  bsrm_data_ram #(
    .ADDR_W (bsrm_pkg::RAM_ADDR_W)
  ) u_ram (
    .clk_sys (clk_sys),
    .wrEn    (ramWrEn),
    .addr    ({q.status[bsrm_pkg::ST_IRP], q.pointer}),
    .wrData  (wrData),
    .rdData  (ramRdData)
  );

  // Pin and brownout events come from registered stages only, so they never feed back through the next state.
  assign pinEvent   = q.pinLevel && q.pinSync[1] == q.pinSync[2] && !q.pinSync[2];
  assign borEvent   = !q.borLevel && q.borSync[1] == q.borSync[2] && q.borSync[2];
  assign otherReset = pinEvent || watchdogTimeout;

  always_comb
  begin
    case (canonIndex(rdIndex))
      bsrm_pkg::IDX_INDIRECT: rdByte = pointsAtPort(q.pointer) ? 8'h00 : ramRdData;
      bsrm_pkg::IDX_OPTION:   rdByte = q.option;
      bsrm_pkg::IDX_PCLOW:    rdByte = q.pc[7:0];
      bsrm_pkg::IDX_STATUS:   rdByte = q.status;
      bsrm_pkg::IDX_POINTER:  rdByte = q.pointer;
      bsrm_pkg::IDX_DIRA:     rdByte = {2'h0, q.dirA};
      bsrm_pkg::IDX_DIRB:     rdByte = q.dirB;
      bsrm_pkg::IDX_DIRC:     rdByte = q.dirC;
      bsrm_pkg::IDX_LATCH:    rdByte = {3'h0, q.latch};
      bsrm_pkg::IDX_INTCTRL:  rdByte = q.intCtrl;
      bsrm_pkg::IDX_PIRQEN:   rdByte = q.pirqEn;
      bsrm_pkg::IDX_CAUSE:    rdByte = {6'h00, q.cause};
      bsrm_pkg::IDX_T2PER:    rdByte = q.t2Per;
      bsrm_pkg::IDX_SERADDR:  rdByte = q.serAddr;
      bsrm_pkg::IDX_SERSTATE: rdByte = {2'h0, q.serState};
      default:                rdByte = 8'h00;
    endcase
  end

  always_comb
  begin
    d = q;
    d.pinSync = {q.pinSync[1:0], externalResetPin_n};
    d.borSync = {q.borSync[1:0], brownoutDetect};
    if (q.pinSync[1] == q.pinSync[2])
    begin
      d.pinLevel = q.pinSync[2];
    end
    if (q.borSync[1] == q.borSync[2])
    begin
      d.borLevel = q.borSync[2];
    end
    d.serState = serialPortStateIn;
    if (pcJump)
    begin
      d.pc = {q.latch[4:3], jumpTarget};
    end
    else if (pcAdvance)
    begin
      d.pc = q.pc + 13'h0001;
    end
    if (wrEn)
    begin
      case (canonIndex(wrIndex))
        bsrm_pkg::IDX_OPTION:  d.option = wrData;
        bsrm_pkg::IDX_PCLOW:   d.pc = {q.latch, wrData};
        bsrm_pkg::IDX_STATUS:
        begin
          d.status[7:5] = wrData[7:5];
          d.status[2:0] = wrData[2:0];
        end
        bsrm_pkg::IDX_POINTER: d.pointer = wrData;
        bsrm_pkg::IDX_DIRA:    d.dirA = wrData[5:0];
        bsrm_pkg::IDX_DIRB:    d.dirB = wrData;
        bsrm_pkg::IDX_DIRC:    d.dirC = wrData;
        bsrm_pkg::IDX_LATCH:   d.latch = wrData[4:0];
        bsrm_pkg::IDX_INTCTRL: d.intCtrl = wrData;
        bsrm_pkg::IDX_PIRQEN:  d.pirqEn = wrData;
        bsrm_pkg::IDX_CAUSE:   d.cause = wrData[1:0];
        bsrm_pkg::IDX_T2PER:   d.t2Per = wrData;
        bsrm_pkg::IDX_SERADDR: d.serAddr = wrData;
        default:               d = d;
      endcase
    end
    // Hardware flag events win over a software clear in the same cycle.
    d.intCtrl[2:0] = d.intCtrl[2:0] | irqFlagSet;
    if (borEvent)
    begin
      d = applyReset(d, 1'b1, 1'b0);
    end
    else if (otherReset)
    begin
      d = applyReset(d, 1'b0, watchdogTimeout);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= RST_Q;
    end
    else
    begin
      q <= d;
    end
  end

  assign programCounter        = q.pc;
  assign timerAndPullupOptions = q.option;
  assign cpuStatusFlags        = q.status;
  assign indirectPointer       = q.pointer;
  assign portADirection        = q.dirA;
  assign portBDirection        = q.dirB;
  assign portCDirection        = q.dirC;
  assign pcHighLatch           = q.latch;
  assign interruptControl      = q.intCtrl;
  assign peripheralIrqEnable   = q.pirqEn;
  assign resetCauseFlags       = q.cause;
  assign timer2Period          = q.t2Per;
  assign serialPortAddress     = q.serAddr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  hole_read_zero_a: assert property (
    rdEn && canonIndex(rdIndex) == 8'h8d |=> rvalid && rdata == 32'h0000_0000)
    else $error("Unimplemented index did not read as zero.");
  hole_write_ignored_a: assert property (
    wrEn && wrIndex == 8'h8f && !pcAdvance && !pcJump && !borEvent && !otherReset
    |=> $stable(q.option) && $stable(q.pc) && $stable(q.dirB) && $stable(q.pointer))
    else $error("Write to unimplemented index changed state.");
  mirror_write_a: assert property (
    wrEn && wrIndex == 8'h04 && !borEvent && !otherReset |=> q.pointer == $past(wrData))
    else $error("Bank-zero pointer write missed the shared register.");
  pc_high_kept_a: assert property (
    wrEn && canonIndex(wrIndex) != 8'h82 && !pcAdvance && !pcJump && !borEvent &&
    !otherReset |=> programCounter[12:8] == $past(programCounter[12:8]))
    else $error("Counter high bits changed without a counter update.");
  pcl_load_a: assert property (
    wrEn && canonIndex(wrIndex) == 8'h82 && !borEvent && !otherReset
    |=> programCounter == {$past(pcHighLatch), $past(wrData)})
    else $error("Counter low write did not take the latch.");
  latch_only_a: assert property (
    wrEn && wrIndex == 8'h8a && !pcAdvance && !pcJump && !borEvent && !otherReset
    |=> pcHighLatch == $past(wrData[4:0]) && $stable(programCounter))
    else $error("Latch write reached the counter.");
  watchdog_reset_a: assert property (
    watchdogTimeout && !borEvent |=> !cpuStatusFlags[4] && cpuStatusFlags[3] &&
    $stable(resetCauseFlags) && programCounter == 13'h0000 && pcHighLatch == 5'h00)
    else $error("Watchdog reset loaded wrong values.");
  unchanged_keep_a: assert property (
    otherReset && !borEvent && !wrEn |=> $stable(indirectPointer) &&
    cpuStatusFlags[2:0] == $past(cpuStatusFlags[2:0]))
    else $error("Non-power-up reset altered kept bits.");
  indirect_no_store_a: assert property (
    wrEn && wrIndex == 8'h00 && !pointsAtPort(q.pointer) |-> ramWrEn ##1
    $stable(indirectPointer))
    else $error("Indirect write missed memory or touched the pointer.");

  cover_write_c: cover property (wrEn ##[1:3] bvalid && bready);
  cover_read_c: cover property (rdEn ##1 rvalid && rready);
  cover_wdt_c: cover property (watchdogTimeout ##1 !cpuStatusFlags[4]);
  cover_bor_c: cover property (borEvent);
endmodule : bsrm_top

//--- testbench/bank1_special_register_map_bench.sv
`timescale 1ns/100ps
module bank1_special_register_map_bench;
  logic        clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pcAdvance, pcJump, externalResetPin_n, brownoutDetect, watchdogTimeout;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rdV;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resetCauseFlags;
  logic [10:0] jumpTarget;
  logic [2:0]  irqFlagSet;
  logic [5:0]  serialPortStateIn, portADirection;
  logic [12:0] programCounter;
  logic [7:0]  timerAndPullupOptions, cpuStatusFlags, indirectPointer, portBDirection;
  logic [7:0]  portCDirection, interruptControl, peripheralIrqEnable, timer2Period;
  logic [7:0]  serialPortAddress;
  logic [4:0]  pcHighLatch;
  int          n_errors, total_checks;
  logic [7:0]  rstIdx [15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                              8'h8a, 8'h8b, 8'h8c, 8'h8e, 8'h92, 8'h93, 8'h94};
  logic [7:0]  rstVal [15] = '{8'h00, 8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff,
                              8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  logic [7:0]  gapIdx [12] = '{8'h01, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h88, 8'h89, 8'h8d,
                              8'h8f, 8'h90, 8'h91, 8'h95};
  logic [7:0]  rwIdx [7] = '{8'h81, 8'h85, 8'h86, 8'h87, 8'h8c, 8'h92, 8'h93};

  bsrm_top u_dut (
    .clk_sys(clk_sys), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pcAdvance(pcAdvance),
    .pcJump(pcJump), .jumpTarget(jumpTarget), .externalResetPin_n(externalResetPin_n),
    .brownoutDetect(brownoutDetect), .watchdogTimeout(watchdogTimeout),
    .irqFlagSet(irqFlagSet), .serialPortStateIn(serialPortStateIn),
    .programCounter(programCounter), .timerAndPullupOptions(timerAndPullupOptions),
    .cpuStatusFlags(cpuStatusFlags), .indirectPointer(indirectPointer),
    .portADirection(portADirection), .portBDirection(portBDirection),
    .portCDirection(portCDirection), .pcHighLatch(pcHighLatch),
    .interruptControl(interruptControl), .peripheralIrqEnable(peripheralIrqEnable),
    .resetCauseFlags(resetCauseFlags), .timer2Period(timer2Period),
    .serialPortAddress(serialPortAddress));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Both channels are offered together and each is dropped once taken.
  task automatic axWrite(input logic [7:0] idx, input logic [7:0] val);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, val};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    // Response ready stays high between calls, and each call still drives it high again.
    check({30'h0000_0000, bresp}, {30'h0000_0000, bsrm_pkg::AXI_OKAY});
  endtask : axWrite

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rdV = rdata;
    check(rdV, {24'h00_0000, exp});
    check({30'h0000_0000, rresp}, {30'h0000_0000, bsrm_pkg::AXI_OKAY});
  endtask : rdChk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : settle

  function automatic logic [7:0] regOut(input logic [7:0] idx);
    case (idx)
      8'h81:   return timerAndPullupOptions;
      8'h85:   return {2'b00, portADirection};
      8'h86:   return portBDirection;
      8'h87:   return portCDirection;
      8'h8c:   return peripheralIrqEnable;
      8'h92:   return timer2Period;
      default: return serialPortAddress;
    endcase
  endfunction : regOut

  // A hang in any handshake is cut short well past the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0]  idx;
    logic [7:0]  val;
    logic [31:0] r;
    seed = 32'h0000_eb2e;
    n_errors = 0;
    total_checks = 0;
    {awvalid, wvalid, bready, arvalid, rready, pcAdvance, pcJump} = 7'h00;
    {brownoutDetect, watchdogTimeout} = 2'h0;
    externalResetPin_n = 1'b1;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    jumpTarget = 11'h000;
    irqFlagSet = 3'h0;
    serialPortStateIn = 6'h00;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 15; i++) rdChk(rstIdx[i], rstVal[i]);
    for (int i = 0; i < 12; i++)
    begin
      axWrite(gapIdx[i], 8'hff);
      rdChk(gapIdx[i], 8'h00);
    end
    for (int i = 0; i < 40; i++)
    begin
      r = xs();
      idx = rwIdx[r % 7];
      r = xs();
      val = (idx == 8'h8c) ? (r[7:0] & 8'h3f) : r[7:0];
      axWrite(idx, val);
      rdChk(idx, (idx == 8'h85) ? (val & 8'h3f) : val);
      check({24'h00_0000, regOut(idx)},
            {24'h00_0000, (idx == 8'h85) ? (val & 8'h3f) : val});
    end
    // A write whose low byte lane is not strobed must leave the register alone.
    axWrite(8'h81, 8'h5a);
    wstrb <= 4'h0;
    axWrite(8'h81, 8'h00);
    wstrb <= 4'h1;
    check({24'h00_0000, timerAndPullupOptions}, 32'h0000_005a);
    axWrite(8'h04, 8'h85);
    rdChk(8'h84, 8'h85);
    axWrite(8'h80, 8'ha5);
    axWrite(8'h84, 8'h86);
    axWrite(8'h00, 8'h3c);
    axWrite(8'h84, 8'h85);
    rdChk(8'h00, 8'ha5);
    axWrite(8'h84, 8'h80);
    rdChk(8'h80, 8'h00);
    axWrite(8'h84, 8'h86);
    rdChk(8'h80, 8'h3c);
    axWrite(8'h0a, 8'h15);
    check({19'h0_0000, programCounter}, 32'h0000_0000);
    axWrite(8'h82, 8'h34);
    check({19'h0_0000, programCounter}, 32'h0000_1534);
    pcAdvance <= 1'b1;
    @(posedge clk_sys);
    pcAdvance <= 1'b0;
    @(posedge clk_sys);
    check({19'h0_0000, programCounter}, 32'h0000_1535);
    r = xs();
    jumpTarget <= r[10:0];
    pcJump <= 1'b1;
    @(posedge clk_sys);
    pcJump <= 1'b0;
    @(posedge clk_sys);
    check({19'h0_0000, programCounter}, {19'h0_0000, 2'b10, r[10:0]});
    rdChk(8'h82, r[7:0]);
    rdChk(8'h8a, 8'h15);
    serialPortStateIn <= r[16:11];
    axWrite(8'h94, 8'hff);
    rdChk(8'h94, {2'b00, r[16:11]});
    axWrite(8'h83, 8'h05);
    axWrite(8'h81, 8'h12);
    axWrite(8'h8b, 8'hf1);
    axWrite(8'h84, 8'h5a);
    axWrite(8'h8e, 8'h03);
    watchdogTimeout <= 1'b1;
    @(posedge clk_sys);
    watchdogTimeout <= 1'b0;
    settle(2);
    check({24'h00_0000, cpuStatusFlags}, 32'h0000_000d);
    check({24'h00_0000, timerAndPullupOptions}, 32'h0000_00ff);
    check({24'h00_0000, interruptControl}, 32'h0000_0001);
    check({24'h00_0000, indirectPointer}, 32'h0000_005a);
    check({30'h0000_0000, resetCauseFlags}, 32'h0000_0003);
    check({19'h0_0000, programCounter}, 32'h0000_0000);
    axWrite(8'h81, 8'h12);
    externalResetPin_n <= 1'b0;
    settle(6);
    externalResetPin_n <= 1'b1;
    settle(6);
    check({24'h00_0000, cpuStatusFlags}, 32'h0000_000d);
    check({24'h00_0000, timerAndPullupOptions}, 32'h0000_00ff);
    axWrite(8'h81, 8'h12);
    brownoutDetect <= 1'b1;
    settle(6);
    brownoutDetect <= 1'b0;
    settle(2);
    check({24'h00_0000, cpuStatusFlags}, 32'h0000_001d);
    check({30'h0000_0000, resetCauseFlags}, 32'h0000_0002);
    check({24'h00_0000, timerAndPullupOptions}, 32'h0000_00ff);
    irqFlagSet <= 3'h4;
    @(posedge clk_sys);
    irqFlagSet <= 3'h0;
    rdChk(8'h8b, 8'h05);
    tally_and_finish();
  end
endmodule : bank1_special_register_map_bench
